// ===== hdl/si_regs.vh
`ifndef SI_REGS_VH
`define SI_REGS_VH

// register map (byte address on the apb bus)
`define SI_ADDR_CTRL_STATUS 8'h00
`define SI_CTRL_STATUS_RESET 8'h00

// bit positions in the control/status register
`define SI_BIT_RSVD7 7
`define SI_BIT_VOLTAGE_WARN_IRQ_EN 6
`define SI_BIT_VOLTAGE_WARN_FLAG 5
`define SI_BIT_LOWVOLT_RESET_FLAG 4
`define SI_BIT_RSVD3 3
`define SI_BIT_CLOCK_FAIL_IRQ_EN 2
`define SI_BIT_CLOCK_FAIL_FLAG 1
`define SI_BIT_DOG_RESET_FLAG 0

// dead time between clock enables when switching oscillators
`define SI_SWITCH_GAP_NS 160
`define SI_PCLK_PERIOD_NS 40
`define SI_SWITCH_GAP_CYCLES \
    ((`SI_SWITCH_GAP_NS + `SI_PCLK_PERIOD_NS - 1) / `SI_PCLK_PERIOD_NS)

// clock guard states
`define SI_G_MAIN 2'h0
`define SI_G_TO_BACKUP 2'h1
`define SI_G_BACKUP 2'h2
`define SI_G_TO_MAIN 2'h3

`endif

// ===== hdl/si_sync.v
`timescale 1ns/1ps
// three-stage input synchroniser; output moves once stages two and three agree
module si_sync (
    input wire pclk,
    input wire presetn,
    input wire din,
    output reg dout
);
    reg s1;
    reg s2;
    reg s3;

    // shift chain and agreement filter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule // si_sync

// ===== hdl/si_guard.v
`timescale 1ns/1ps
`include "si_regs.vh"
// clock guard: break-before-make switch between main and backup oscillator
module si_guard #(
    parameter GAP = `SI_SWITCH_GAP_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire enable,
    input wire freeze,
    input wire main_ok,
    output reg main_clk_en,
    output reg backup_clk_en,
    output reg backup_osc_on,
    output reg on_backup
);
    reg [1:0] state;
    reg [1:0] next_state;
    reg [7:0] gap_cnt;

    // next state; hold the state while frozen
    always @* begin
        next_state = state;
        case (state)
            `SI_G_MAIN: begin
                if (enable && !main_ok && !freeze) begin
                    next_state = `SI_G_TO_BACKUP;
                end
            end
            `SI_G_TO_BACKUP: begin
                if (!freeze && gap_cnt == 8'h00) begin
                    next_state = `SI_G_BACKUP;
                end
            end
            `SI_G_BACKUP: begin
                if (!freeze && (main_ok || !enable)) begin
                    next_state = `SI_G_TO_MAIN;
                end
            end
            `SI_G_TO_MAIN: begin
                if (!freeze && gap_cnt == 8'h00) begin
                    next_state = `SI_G_MAIN;
                end
            end
            default: begin
                next_state = `SI_G_MAIN;
            end
        endcase
    end

    // state, gap counter and registered enables
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= `SI_G_MAIN;
            gap_cnt <= 8'h00;
            main_clk_en <= 1'b1;
            backup_clk_en <= 1'b0;
            backup_osc_on <= 1'b0;
            on_backup <= 1'b0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                gap_cnt <= GAP[7:0] - 8'h01;
            end else if (!freeze && gap_cnt != 8'h00) begin
                gap_cnt <= gap_cnt - 8'h01;
            end
            // both enables low during gaps, so no runt pulse
            main_clk_en <= (next_state == `SI_G_MAIN);
            backup_clk_en <= (next_state == `SI_G_BACKUP) && !freeze;
            // backup oscillator off while halted
            backup_osc_on <= !freeze && (next_state != `SI_G_MAIN);
            on_backup <= (next_state == `SI_G_BACKUP);
        end
    end
endmodule // si_guard

// ===== hdl/si_top.v
`timescale 1ns/1ps
`include "si_regs.vh"
module si_top #(
    parameter GAP = `SI_SWITCH_GAP_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire por_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire opt_lvd_en,
    input wire opt_guard_en,
    input wire main_osc_ok,
    input wire voltage_cmp,
    input wire rst_src_lowvolt,
    input wire rst_src_dog,
    input wire cc_irq_mask,
    input wire wait_mode,
    input wire halt_mode,
    input wire voltage_isr_enter,
    output reg clock_fail_irq,
    output reg voltage_warn_irq,
    output reg wake_from_wait,
    output reg main_clk_en,
    output reg backup_clk_en,
    output reg backup_osc_on
);
    wire lvd_en;
    wire guard_en;
    wire main_ok;
    wire voltage_low;
    wire g_main_en;
    wire g_backup_en;
    wire g_osc_on;
    wire on_backup;
    wire access;
    wire hit;
    wire wr_acc;
    wire rd_acc;
    wire [7:0] reg_view;
    reg voltage_warn_irq_en;
    reg clock_fail_irq_en;
    reg clock_fail_flag;
    reg voltage_warn_flag;
    reg voltage_pend;
    reg lowvolt_reset_flag;
    reg dog_reset_flag;
    reg first_cycle;

    // option pins and analog status come from outside the clock domain
    si_sync u_sync_lvd (
        .pclk(pclk),
        .presetn(presetn),
        .din(opt_lvd_en),
        .dout(lvd_en)
    );
    si_sync u_sync_guard (
        .pclk(pclk),
        .presetn(presetn),
        .din(opt_guard_en),
        .dout(guard_en)
    );
    si_sync u_sync_osc (
        .pclk(pclk),
        .presetn(presetn),
        .din(main_osc_ok),
        .dout(main_ok)
    );
    si_sync u_sync_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .din(voltage_cmp),
        .dout(voltage_low)
    );

    // clock guard; frozen state survives halt, presetn restarts it
    si_guard #(
        .GAP(GAP)
    ) u_guard (
        .pclk(pclk),
        .presetn(presetn),
        .enable(guard_en),
        .freeze(halt_mode),
        .main_ok(main_ok),
        .main_clk_en(g_main_en),
        .backup_clk_en(g_backup_en),
        .backup_osc_on(g_osc_on),
        .on_backup(on_backup)
    );

    // apb decode; one register word at the base address
    assign access = psel && penable && pready;
    assign hit = (paddr == `SI_ADDR_CTRL_STATUS);
    assign wr_acc = access && pwrite && hit && !halt_mode;
    assign rd_acc = access && !pwrite && hit;

    // register image as software sees it
    assign reg_view = {
        1'b0,
        voltage_warn_irq_en,
        voltage_warn_flag,
        lowvolt_reset_flag,
        1'b0,
        clock_fail_irq_en,
        clock_fail_flag && guard_en,
        dog_reset_flag
    };

    // apb answer: ready in the cycle after setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                pslverr <= !hit;
                if (!pwrite && hit) begin
                    prdata <= {24'h000000, reg_view};
                end else begin
                    prdata <= 32'h00000000;
                end
            end else begin
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
            end
        end
    end

    // software enables; writes blocked while halted
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            voltage_warn_irq_en <= 1'b0;
            clock_fail_irq_en <= 1'b0;
        end else if (wr_acc) begin
            voltage_warn_irq_en <= pwdata[`SI_BIT_VOLTAGE_WARN_IRQ_EN];
            clock_fail_irq_en <= pwdata[`SI_BIT_CLOCK_FAIL_IRQ_EN];
        end
    end

    // clock fail flag: set wins over the clearing read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_fail_flag <= 1'b0;
        end else if (halt_mode) begin
            clock_fail_flag <= clock_fail_flag;
        end else if (on_backup && guard_en) begin
            clock_fail_flag <= 1'b1;
        end else if (rd_acc && main_ok) begin
            clock_fail_flag <= 1'b0;
        end
    end

    // voltage flag follows comparator gated by lvd_en; each change latches a request while the warning irq and lvd_en are enabled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            voltage_warn_flag <= 1'b0;
            voltage_pend <= 1'b0;
        end else if (!halt_mode) begin
            voltage_warn_flag <= voltage_low && lvd_en;
            if (voltage_warn_irq_en && lvd_en &&
                    ((voltage_low && lvd_en) != voltage_warn_flag)) begin
                voltage_pend <= 1'b1;
            end else if (voltage_isr_enter) begin
                voltage_pend <= 1'b0;
            end
        end
    end

    // reset source flags live on power-on reset only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    // capture source at first edge after release, then software clears
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            lowvolt_reset_flag <= 1'b0;
            dog_reset_flag <= 1'b0;
        end else if (first_cycle) begin
            if (rst_src_lowvolt) begin
                lowvolt_reset_flag <= 1'b1;
                dog_reset_flag <= 1'b0;
            end else if (rst_src_dog) begin
                dog_reset_flag <= 1'b1;
            end else begin
                dog_reset_flag <= 1'b0;
            end
        end else if (wr_acc) begin
            if (!pwdata[`SI_BIT_LOWVOLT_RESET_FLAG]) begin
                lowvolt_reset_flag <= 1'b0;
            end
            if (!pwdata[`SI_BIT_DOG_RESET_FLAG]) begin
                dog_reset_flag <= 1'b0;
            end
        end
    end

    // interrupt lines; none of them acts during halt
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_fail_irq <= 1'b0;
            voltage_warn_irq <= 1'b0;
            wake_from_wait <= 1'b0;
        end else begin
            clock_fail_irq <= clock_fail_flag && clock_fail_irq_en &&
                guard_en && !cc_irq_mask && !halt_mode;
            voltage_warn_irq <= voltage_pend && voltage_warn_irq_en &&
                lvd_en && !cc_irq_mask && !halt_mode;
            wake_from_wait <= wait_mode && !halt_mode &&
                ((clock_fail_flag && clock_fail_irq_en && guard_en) ||
                (voltage_pend && voltage_warn_irq_en && lvd_en));
        end
    end

    // clock enables registered once more at the top boundary
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_clk_en <= 1'b1;
            backup_clk_en <= 1'b0;
            backup_osc_on <= 1'b0;
        end else begin
            main_clk_en <= g_main_en;
            backup_clk_en <= g_backup_en;
            backup_osc_on <= g_osc_on && !halt_mode;
        end
    end
endmodule // si_top

// ===== tb/si_checker.sv
`timescale 1ns/1ps
// watches the top ports for gate, register and interrupt relations
module si_checker (
    input wire pclk,
    input wire presetn,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire opt_lvd_en,
    input wire opt_guard_en,
    input wire cc_irq_mask,
    input wire halt_mode,
    input wire clock_fail_irq,
    input wire voltage_warn_irq,
    input wire main_clk_en,
    input wire backup_clk_en,
    input wire backup_osc_on
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // gate overlap and reserved bits
    AST_CLK_EXCL: assert property (
        !(main_clk_en && backup_clk_en)) else $error("gates overlap");
    AST_RSVD_ZERO: assert property (
        pready && !pwrite |-> prdata[7] == 1'b0 && prdata[3] == 1'b0)
        else $error("reserved bit set");
    // interrupt, backup oscillator and flag gating by halt, mask and options
    AST_HALT_IRQ: assert property (
        halt_mode |=> !clock_fail_irq && !voltage_warn_irq)
        else $error("irq during halt");
    AST_MASK_IRQ: assert property (
        cc_irq_mask |=> !clock_fail_irq && !voltage_warn_irq)
        else $error("irq while masked");
    AST_HALT_OSC: assert property (
        halt_mode[*3] |-> !backup_osc_on) else $error("backup on in halt");
    AST_GUARD_OFF_IRQ: assert property (
        !opt_guard_en[*8] |-> !clock_fail_irq) else $error("fail irq");
    AST_LVD_OFF_IRQ: assert property (
        !opt_lvd_en[*8] |-> !voltage_warn_irq) else $error("warn irq");
    AST_FLAG_OFF: assert property (
        (!opt_guard_en[*8] ##0 (pready && !pwrite)) |-> !prdata[1])
        else $error("fail flag read as one");
endmodule // si_checker

bind si_top si_checker u_chk (.pclk(pclk), .presetn(presetn),
    .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .opt_lvd_en(opt_lvd_en), .opt_guard_en(opt_guard_en),
    .cc_irq_mask(cc_irq_mask), .halt_mode(halt_mode),
    .clock_fail_irq(clock_fail_irq), .voltage_warn_irq(voltage_warn_irq),
    .main_clk_en(main_clk_en), .backup_clk_en(backup_clk_en),
    .backup_osc_on(backup_osc_on));

// ===== tb/si_cpu_model.sv
`timescale 1ns/1ps
// cpu side: enters the warning service routine some cycles after a request
module si_cpu_model #(
    parameter LAT = 3
) (
    input wire pclk,
    input wire presetn,
    input wire irq,
    output reg isr_enter
);
    reg [3:0] cnt;
    // one-cycle entry pulse after LAT+1 cycles of a standing request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            isr_enter <= 1'b0;
        end else begin
            isr_enter <= 1'b0;
            cnt <= 4'h0;
            if (irq && !isr_enter && cnt == LAT) begin
                isr_enter <= 1'b1;
            end else if (irq && !isr_enter) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // si_cpu_model

// ===== tb/system_integrity_status_test.sv
`timescale 1ns/1ps
// random and corner-case register, guard, warning and reset-flag tests
module system_integrity_status_test;
    reg pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0;
    reg pwrite = 0, opt_lvd_en = 0, opt_guard_en = 0, main_osc_ok = 1;
    reg voltage_cmp = 0, rst_src_lowvolt = 0, rst_src_dog = 0;
    reg cc_irq_mask = 0, wait_mode = 0, halt_mode = 0;
    reg [7:0] paddr = 8'h00, r, d;
    reg [31:0] pwdata = 32'h0;
    reg e;
    wire [31:0] prdata;
    wire pready, pslverr, isr_enter, cf_irq, vw_irq, wake, m_en, b_en;
    wire b_osc;
    integer n_errors = 0, compares = 0, seed = 32'h568c, i, k;

    // clock
    always #20 pclk = ~pclk;

    // device and cpu partner
    si_top #(.GAP(2)) dut (.pclk(pclk), .presetn(presetn), .por_n(por_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .opt_lvd_en(opt_lvd_en),
        .opt_guard_en(opt_guard_en), .main_osc_ok(main_osc_ok),
        .voltage_cmp(voltage_cmp), .rst_src_lowvolt(rst_src_lowvolt),
        .rst_src_dog(rst_src_dog), .cc_irq_mask(cc_irq_mask),
        .wait_mode(wait_mode), .halt_mode(halt_mode),
        .voltage_isr_enter(isr_enter), .clock_fail_irq(cf_irq),
        .voltage_warn_irq(vw_irq), .wake_from_wait(wake),
        .main_clk_en(m_en), .backup_clk_en(b_en), .backup_osc_on(b_osc));
    si_cpu_model #(.LAT(3)) cpu (.pclk(pclk), .presetn(presetn),
        .irq(vw_irq), .isr_enter(isr_enter));

    task chk(input string name, input [31:0] seen, input [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task apb(input w, input [7:0] a, input [7:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        // poll between edges; registered answer stands to the next edge
        @(negedge pclk);
        while (pready !== 1'b1 && i < 20) begin
            @(negedge pclk);
            i = i + 1;
        end
        r = prdata[7:0];
        e = pslverr;
        chk("pready", pready, 1);
        if (i >= 20) begin
            report_and_stop;
        end
        // access edge: write lands, then release; read data was taken at the negedge before it
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task do_reset;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    function [7:0] exp_rw(input [7:0] wd);
        exp_rw = wd & 8'h44;
    endfunction

    function [7:0] exp_src(input lv, input dog);
        exp_src = {3'b000, lv, 3'b000, dog};
    endfunction

    task wait_on(input string name, input exp);
        @(negedge pclk);
        for (k = 0; k < 80 && (name == "b" ? b_en : name == "m" ? m_en :
            name == "c" ? cf_irq : name == "w" ? wake : vw_irq) !== exp;
            k = k + 1) @(negedge pclk);
        chk(name, k < 80, 1);
        if (k >= 80) begin
            report_and_stop;
        end
        // back on a rising edge so later stimulus starts right after it
        @(posedge pclk);
    endtask

    task report_and_stop;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // hang guard
    initial begin
        #4000000;
        n_errors = n_errors + 1;
        report_and_stop;
    end

    // main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(0, 8'h00, 8'h00);
        chk("reset", r, 8'h00);
        for (k = 0; k < 5; k = k + 1) begin
            d = (k == 0) ? 8'hff : $random(seed);
            apb(1, 8'h00, d);
            apb(0, 8'h00, 8'h00);
            chk("rw", r, exp_rw(d));
        end
        d = $random(seed);
        apb(0, {d[7:3], 3'b100}, 8'h00);
        chk("err", {e, r}, 9'h100);
        $display("test registers done");
        opt_guard_en <= 1'b1;
        apb(1, 8'h00, 8'h04);
        wait_mode <= 1'b1;
        main_osc_ok <= 1'b0;
        wait_on("b", 1'b1);
        chk("gates", {m_en, b_en}, 2'b01);
        wait_on("c", 1'b1);
        wait_on("w", 1'b1);
        apb(0, 8'h00, 8'h00);
        chk("fail", r, 8'h06);
        apb(0, 8'h00, 8'h00);
        chk("fail kept", r, 8'h06);
        main_osc_ok <= 1'b1;
        wait_mode <= 1'b0;
        wait_on("m", 1'b1);
        apb(0, 8'h00, 8'h00);
        apb(0, 8'h00, 8'h00);
        chk("fail clr", r, 8'h04);
        $display("test guard done");
        opt_lvd_en <= 1'b1;
        apb(1, 8'h00, 8'h40);
        voltage_cmp <= 1'b1;
        wait_on("v", 1'b1);
        wait_on("v", 1'b0);
        apb(0, 8'h00, 8'h00);
        chk("warn", r, 8'h60);
        cc_irq_mask <= 1'b1;
        voltage_cmp <= 1'b0;
        repeat (12) @(posedge pclk);
        chk("masked", vw_irq, 0);
        cc_irq_mask <= 1'b0;
        wait_on("v", 1'b1);
        wait_on("v", 1'b0);
        apb(0, 8'h00, 8'h00);
        chk("warn off", r, 8'h40);
        $display("test warning done");
        main_osc_ok <= 1'b0;
        wait_on("b", 1'b1);
        halt_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("osc off", b_osc, 0);
        apb(1, 8'h00, 8'h00);
        apb(0, 8'h00, 8'h00);
        chk("frozen", r, 8'h42);
        halt_mode <= 1'b0;
        wait_on("b", 1'b1);
        main_osc_ok <= 1'b1;
        wait_on("m", 1'b1);
        $display("test halt done");
        rst_src_dog <= 1'b1;
        do_reset;
        chk("guard restart", {m_en, b_en}, 2'b10);
        apb(0, 8'h00, 8'h00);
        chk("dog", r, exp_src(0, 1));
        rst_src_dog <= 1'b0;
        rst_src_lowvolt <= 1'b1;
        do_reset;
        apb(0, 8'h00, 8'h00);
        chk("lowvolt", r, exp_src(1, 0));
        rst_src_lowvolt <= 1'b0;
        rst_src_dog <= 1'b1;
        do_reset;
        apb(0, 8'h00, 8'h00);
        chk("kept", r, exp_src(1, 1));
        apb(1, 8'h00, 8'hff);
        apb(0, 8'h00, 8'h00);
        chk("ones", r, 8'h55);
        apb(1, 8'h00, 8'h00);
        apb(0, 8'h00, 8'h00);
        chk("cleared", r, 8'h00);
        $display("test reset flags done");
        report_and_stop;
    end
endmodule // system_integrity_status_test
